// ---- logic/dcc_pkg.sv ----
// Package for the four-channel block transfer controller.
// Assumes one system clock; peripherals sit on the same clock.
package dcc_pkg;

  localparam int NCH = 4;
  localparam int SRC_N = 128;

  // Register map, byte offsets
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_SEL = 5'h04;
  localparam logic [4:0] OFF_STA = 5'h08;
  localparam logic [4:0] OFF_STB = 5'h0c;
  localparam logic [4:0] OFF_PAD = 5'h10;
  localparam logic [4:0] OFF_CNT = 5'h14;
  localparam logic [4:0] OFF_STAT = 5'h18;
  localparam logic [7:0] OFF_COLL = 8'h80;
  localparam logic [15:0] RST_VAL = 16'h0000;

  // Addressing modes
  localparam logic [1:0] AM_POSTINC = 2'h0;
  localparam logic [1:0] AM_NOINC = 2'h1;
  localparam logic [1:0] AM_PERIPH = 2'h2;

  // Request source codes
  localparam logic [7:0] SEL_EXT_INT_ZERO = 8'h00;
  localparam logic [7:0] SEL_CAPTURE_TWO = 8'h05;
  localparam logic [7:0] SEL_COMPARE_ONE = 8'h02;
  localparam logic [7:0] SEL_SERIAL_ONE_RX = 8'h0b;
  localparam logic [7:0] SEL_CAN_RX = 8'h22;
  localparam logic [7:0] SEL_CONVERTER_DONE = 8'h0d;

  // Peripheral data addresses
  localparam logic [15:0] ADDR_CAPTURE_TWO_BUFFER = 16'h014c;
  localparam logic [15:0] ADDR_COMPARE_ONE_PRIMARY = 16'h0906;
  localparam logic [15:0] ADDR_COMPARE_ONE_SECONDARY = 16'h0904;
  localparam logic [15:0] ADDR_SERIAL_ONE_RECEIVE = 16'h0226;
  localparam logic [15:0] ADDR_CAN_RECEIVE_DATA = 16'h0440;
  localparam logic [15:0] ADDR_CONVERTER_RESULT_ZERO = 16'h0300;

  // Channel control word, bit 0 is enable
  typedef struct packed {
    logic [5:0] rsvd;
    logic       alt_target;
    logic       sw_force;
    logic       pingpong;
    logic       oneshot;
    logic [1:0] amode;
    logic       half;
    logic       size_byte;
    logic       to_periph;
    logic       en;
  } dcc_ctrl_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dcc_rreq_t;

  // Data bus request toward memory and peripherals
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        rd;
    logic        wr;
    logic        size_byte;
  } dcc_bus_t;

endpackage

// ---- logic/dcc_top.sv ----
// Four-channel block transfer controller: registers, arbiter, engine.
// Assumes a data bus whose read data stands the cycle after rd.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire dcc_rreq_t          rreq,
  output logic [15:0]             rdata,
  input  wire logic [SRC_N-1:0]   src_req,
  input  wire logic               ext_int0_pin,
  input  wire logic [15:0]        periph_addr,
  output dcc_bus_t                bus,
  input  wire logic [15:0]        bus_rdata,
  output logic [NCH-1:0]          chan_irq
);

  typedef enum {ST_IDLE, ST_READ, ST_CAPT, ST_WRITE, ST_DONE} dcc_st_t;

  dcc_ctrl_t        ctrl_r [NCH];
  logic [7:0]       sel_r  [NCH];
  logic [15:0]      sta_r  [NCH];
  logic [15:0]      stb_r  [NCH];
  logic [15:0]      pad_r  [NCH];
  logic [15:0]      cnt_r  [NCH];
  logic [15:0]      idx_r  [NCH];
  logic [NCH-1:0]   ping_r;
  logic [NCH-1:0]   pend_r;
  logic [NCH-1:0]   lvl_prev_r;
  logic [NCH-1:0]   coll_r;
  logic [NCH-1:0]   irq_r;
  logic [15:0]      rdata_r;
  logic             ext_s1_r;
  logic             ext_s2_r;
  dcc_st_t          st_r;
  logic [1:0]       cur_r;
  dcc_bus_t         bus_r;

  logic [SRC_N-1:0] req_all;
  logic [NCH-1:0]   lvl;
  logic [NCH-1:0]   edge_v;
  logic [NCH-1:0]   force_v;
  logic [NCH-1:0]   elig;
  logic             grant_v;
  logic [1:0]       grant_ch;
  logic [1:0]       wch;
  logic [4:0]       woff;
  logic             wr_ch;
  logic [15:0]      maddr;
  logic [15:0]      paddr;
  logic [15:0]      base;
  logic [16:0]      idx_inc;
  logic [16:0]      half_pt;
  logic             blk_end;
  logic             half_hit;

  // Table of known peripheral data addresses
  function automatic logic [15:0] pad_lookup(input logic [7:0] sel,
                                             input logic to_p,
                                             input logic alt);
    logic [15:0] a;
    a = RST_VAL;
    case (sel)
      SEL_EXT_INT_ZERO: a = RST_VAL;
      SEL_CAPTURE_TWO: a = to_p ? RST_VAL : ADDR_CAPTURE_TWO_BUFFER;
      SEL_COMPARE_ONE: begin
        if (to_p)
          a = alt ? ADDR_COMPARE_ONE_SECONDARY : ADDR_COMPARE_ONE_PRIMARY;
      end
      SEL_SERIAL_ONE_RX: a = to_p ? RST_VAL : ADDR_SERIAL_ONE_RECEIVE;
      SEL_CAN_RX: a = to_p ? RST_VAL : ADDR_CAN_RECEIVE_DATA;
      SEL_CONVERTER_DONE: begin
        if (!to_p)
          a = ADDR_CONVERTER_RESULT_ZERO;
      end
      default: a = RST_VAL;
    endcase
    return a;
  endfunction

  // External interrupt pin synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_int0_pin;
      ext_s2_r <= ext_s1_r;
    end
  end

  // Request vector: timers, captures, pins and the rest
  always_comb begin
    req_all = src_req;
    req_all[SEL_EXT_INT_ZERO[6:0]] = src_req[SEL_EXT_INT_ZERO[6:0]]
                                     | ext_s2_r;
  end

  // Register write decode
  assign wch = rreq.addr[6:5];
  assign woff = rreq.addr[4:0];
  assign wr_ch = rreq.wr && !rreq.addr[7];

  // Per-channel source select, edge detect and force
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      lvl[i] = !sel_r[i][7] && req_all[sel_r[i][6:0]];
      edge_v[i] = lvl[i] && !lvl_prev_r[i] && ctrl_r[i].en;
      force_v[i] = wr_ch && wch == 2'(i) && woff == OFF_CTRL
                   && rreq.wdata[8] && rreq.wdata[0];
      elig[i] = pend_r[i] && ctrl_r[i].en;
    end
  end

  // Fixed priority, lowest channel number wins
  always_comb begin
    grant_v = 1'b0;
    grant_ch = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        grant_v = 1'b1;
        grant_ch = 2'(i);
      end
    end
  end

  // Address generation for the granted channel
  always_comb begin
    base = ping_r[grant_ch] ? stb_r[grant_ch] : sta_r[grant_ch];
    case (ctrl_r[grant_ch].amode)
      AM_NOINC: maddr = base;
      AM_PERIPH: maddr = periph_addr;
      default: maddr = ctrl_r[grant_ch].size_byte
                       ? 16'(base + idx_r[grant_ch])
                       : 16'(base + {idx_r[grant_ch][14:0], 1'b0});
    endcase
    paddr = (pad_r[grant_ch] != RST_VAL) ? pad_r[grant_ch]
            : pad_lookup(sel_r[grant_ch], ctrl_r[grant_ch].to_periph,
                         ctrl_r[grant_ch].alt_target);
  end

  // Block progress of the current channel
  assign idx_inc = {1'b0, idx_r[cur_r]} + 17'h00001;
  assign half_pt = ({1'b0, cnt_r[cur_r]} + 17'h00001) >> 1;
  assign blk_end = idx_r[cur_r] == cnt_r[cur_r];
  assign half_hit = idx_inc == half_pt;

  // Transfer engine: read source, capture, write destination
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      cur_r <= 2'h0;
      bus_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (grant_v) begin
            cur_r <= grant_ch;
            bus_r.rd <= 1'b1;
            bus_r.size_byte <= ctrl_r[grant_ch].size_byte;
            bus_r.addr <= ctrl_r[grant_ch].to_periph ? maddr : paddr;
            bus_r.wdata <= ctrl_r[grant_ch].to_periph ? paddr : maddr;
            st_r <= ST_READ;
          end
        end
        ST_READ: begin
          bus_r.rd <= 1'b0;
          st_r <= ST_CAPT;
        end
        ST_CAPT: begin
          bus_r.wr <= 1'b1;
          bus_r.addr <= bus_r.wdata;
          bus_r.wdata <= bus_r.size_byte ? {8'h00, bus_rdata[7:0]}
                                         : bus_rdata;
          st_r <= ST_WRITE;
        end
        ST_WRITE: begin
          bus_r.wr <= 1'b0;
          st_r <= ST_DONE;
        end
        ST_DONE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Channel registers and block bookkeeping
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_r[i] <= '0;
        sel_r[i] <= SEL_EXT_INT_ZERO;
        sta_r[i] <= RST_VAL;
        stb_r[i] <= RST_VAL;
        pad_r[i] <= RST_VAL;
        cnt_r[i] <= RST_VAL;
        idx_r[i] <= RST_VAL;
      end
      ping_r <= '0;
    end else begin
      if (st_r == ST_DONE) begin
        if (blk_end) begin
          idx_r[cur_r] <= RST_VAL;
          if (ctrl_r[cur_r].oneshot)
            ctrl_r[cur_r].en <= 1'b0;
          if (ctrl_r[cur_r].pingpong)
            ping_r[cur_r] <= !ping_r[cur_r];
        end else begin
          idx_r[cur_r] <= idx_inc[15:0];
        end
      end
      if (wr_ch) begin
        case (woff)
          OFF_CTRL: begin
            ctrl_r[wch] <= rreq.wdata;
            ctrl_r[wch].sw_force <= 1'b0;
            ctrl_r[wch].rsvd <= '0;
            idx_r[wch] <= RST_VAL;
            ping_r[wch] <= 1'b0;
          end
          OFF_SEL: sel_r[wch] <= rreq.wdata[7:0];
          OFF_STA: sta_r[wch] <= rreq.wdata;
          OFF_STB: stb_r[wch] <= rreq.wdata;
          OFF_PAD: pad_r[wch] <= rreq.wdata;
          OFF_CNT: cnt_r[wch] <= rreq.wdata;
          default: ;
        endcase
      end
    end
  end

  // Pending requests; a new request beats the grant clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= '0;
      lvl_prev_r <= '0;
    end else begin
      lvl_prev_r <= lvl;
      for (int i = 0; i < NCH; i++) begin
        if (st_r == ST_IDLE && grant_v && grant_ch == 2'(i))
          pend_r[i] <= 1'b0;
        if (!ctrl_r[i].en)
          pend_r[i] <= 1'b0;
        if (edge_v[i] || force_v[i])
          pend_r[i] <= 1'b1;
      end
    end
  end

  // Collision flags: force meets a pending or arriving request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coll_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_ch && wch == 2'(i) && woff == OFF_CTRL && !rreq.wdata[0])
          coll_r[i] <= 1'b0;
        if (force_v[i] && (pend_r[i] || edge_v[i]))
          coll_r[i] <= 1'b1;
      end
    end
  end

  // CPU interrupt at half or full block
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= '0;
    end else begin
      irq_r <= '0;
      if (st_r == ST_DONE) begin
        if (ctrl_r[cur_r].half)
          irq_r[cur_r] <= half_hit;
        else
          irq_r[cur_r] <= blk_end;
      end
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= RST_VAL;
    end else begin
      rdata_r <= RST_VAL;
      if (rreq.rd) begin
        if (rreq.addr == OFF_COLL)
          rdata_r <= {12'h000, coll_r};
        else if (!rreq.addr[7]) begin
          case (woff)
            OFF_CTRL: rdata_r <= ctrl_r[wch];
            OFF_SEL: rdata_r <= {8'h00, sel_r[wch]};
            OFF_STA: rdata_r <= sta_r[wch];
            OFF_STB: rdata_r <= stb_r[wch];
            OFF_PAD: rdata_r <= pad_r[wch];
            OFF_CNT: rdata_r <= cnt_r[wch];
            OFF_STAT: rdata_r <= {ping_r[wch], pend_r[wch], idx_r[wch][13:0]};
            default: rdata_r <= RST_VAL;
          endcase
        end
      end
    end
  end

  assign rdata = rdata_r;
  assign bus = bus_r;
  assign chan_irq = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  prio_zero_a: assert property (
    st_r == ST_IDLE && elig[0] |=> cur_r == 2'h0 && st_r == ST_READ)
    else $error("channel zero not granted first");
  prio_one_a: assert property (
    st_r == ST_IDLE && !elig[0] && elig[1] |=> cur_r == 2'h1)
    else $error("channel one not granted over two and three");
  loser_pend_a: assert property (
    st_r == ST_IDLE && elig[0] && elig[1] |=> pend_r[1])
    else $error("losing channel dropped its request");
  read_write_a: assert property (
    bus_r.rd |=> !bus_r.rd && !bus_r.wr ##1 bus_r.wr ##1 !bus_r.wr)
    else $error("read not followed by one write");
  full_irq_a: assert property (
    st_r == ST_DONE && blk_end && !ctrl_r[cur_r].half |=> irq_r[cur_r])
    else $error("block end without interrupt");
  idx_step_a: assert property (
    st_r == ST_DONE && !blk_end && !wr_ch
    |=> idx_r[cur_r] == 16'($past(idx_r[cur_r]) + 16'h0001))
    else $error("transfer index did not advance");
  oneshot_a: assert property (
    st_r == ST_DONE && blk_end && ctrl_r[cur_r].oneshot && !wr_ch
    |=> !ctrl_r[cur_r].en)
    else $error("one-shot channel still enabled");
  pingpong_a: assert property (
    st_r == ST_DONE && blk_end && ctrl_r[cur_r].pingpong && !wr_ch
    |=> ping_r[cur_r] != $past(ping_r[cur_r]))
    else $error("ping-pong buffer not switched");
  byte_a: assert property (
    bus_r.wr && bus_r.size_byte |-> bus_r.wdata[15:8] == 8'h00)
    else $error("byte transfer carried upper byte");
  collision_a: assert property (
    |(force_v & (pend_r | edge_v))
    |=> (coll_r & $past(force_v)) == $past(force_v))
    else $error("collision not flagged");

  blk_done_c: cover property (st_r == ST_DONE && blk_end);
  coll_c: cover property (coll_r != '0);
  half_c: cover property (st_r == ST_DONE && ctrl_r[cur_r].half
                          && half_hit);
  ping_c: cover property (ping_r[2] ##[1:200] !ping_r[2]);

endmodule

// ---- verification/dcc_mem_model.sv ----
// Memory and peripheral data model facing the controller's data bus.
// Assumes bus.rd is a one-cycle pulse and answers in the next cycle only.
`timescale 1ns/1ps
module dcc_mem_model
  import dcc_pkg::*;
(
  input  wire logic     clk,
  input  wire dcc_bus_t bus,
  output logic [15:0]   bus_rdata
);
  // Start from a known pattern so idle cycles never show unknowns
  initial begin
    bus_rdata = 16'h0f0f;
  end

  // Read data is a scramble of the address; between reads it toggles
  always @(posedge clk) begin
    if (bus.rd === 1'b1) begin
      bus_rdata <= bus.addr ^ 16'ha5c3;
    end else begin
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the four-channel transfer controller.
// Assumes a 10 MHz clock and the data model on the far side of the bus.
`timescale 1ns/1ps
module testbench
  import dcc_pkg::*;
;
  logic             clk;
  logic             resetn;
  dcc_rreq_t        rreq;
  logic [15:0]      rdata;
  logic [SRC_N-1:0] src_req;
  logic             ext_int0_pin;
  logic [15:0]      periph_addr;
  dcc_bus_t         bus;
  logic [15:0]      bus_rdata;
  logic [NCH-1:0]   chan_irq;
  int               err_count;
  int               tests_run;
  int               n;
  logic [7:0]       codes [4];
  logic [15:0]      srcs  [4];

  dcc_top dut (.clk(clk), .resetn(resetn), .rreq(rreq), .rdata(rdata),
    .src_req(src_req), .ext_int0_pin(ext_int0_pin),
    .periph_addr(periph_addr), .bus(bus), .bus_rdata(bus_rdata),
    .chan_irq(chan_irq));

  dcc_mem_model mem (.clk(clk), .bus(bus), .bus_rdata(bus_rdata));

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] ra(input int c, input logic [4:0] o);
    return 8'(c) * CH_STRIDE + {3'h0, o};
  endfunction

  // Register write, one strobe cycle then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    rreq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    rreq <= '0;
    @(posedge clk);
  endtask

  // Register read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rreq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    rreq <= '0;
    @(negedge clk);
    check(rdata, exp);
    @(posedge clk);
  endtask

  task automatic cfg(input int c, input logic [7:0] s,
                     input logic [15:0] a, input logic [15:0] b,
                     input logic [15:0] cnt, input logic [15:0] ctl);
    wr(ra(c, OFF_SEL), {8'h00, s});
    wr(ra(c, OFF_STA), a);
    wr(ra(c, OFF_STB), b);
    wr(ra(c, OFF_CNT), cnt);
    wr(ra(c, OFF_CTRL), ctl);
  endtask

  // One-cycle request level from a peripheral
  task automatic pulse(input logic [7:0] code);
    src_req[code[6:0]] <= 1'b1;
    @(posedge clk);
    src_req[code[6:0]] <= 1'b0;
  endtask

  // Follow one read-write transfer and the interrupt after it
  task automatic xfer(input logic [15:0] sa, input logic [15:0] da,
                      input logic bt, input logic [3:0] irq);
    logic [15:0] f;
    int k;
    f = sa ^ 16'ha5c3;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (bus.rd !== 1'b1 && k < 40);
    check(bus.addr, sa);
    check({15'h0, bus.size_byte}, {15'h0, bt});
    repeat (2) @(negedge clk);
    check({15'h0, bus.wr}, 16'h0001);
    check(bus.addr, da);
    check(bus.wdata, bt ? {8'h00, f[7:0]} : f);
    repeat (2) @(negedge clk);
    check({12'h0, chan_irq}, {12'h0, irq});
    @(posedge clk);
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  // Test sequence
  initial begin
    codes = '{SEL_CAPTURE_TWO, SEL_SERIAL_ONE_RX, SEL_CAN_RX,
              SEL_CONVERTER_DONE};
    srcs = '{ADDR_CAPTURE_TWO_BUFFER, ADDR_SERIAL_ONE_RECEIVE,
             ADDR_CAN_RECEIVE_DATA, ADDR_CONVERTER_RESULT_ZERO};
    err_count = 0;
    tests_run = 0;
    resetn = 1'b0;
    rreq = '0;
    src_req = '0;
    ext_int0_pin = 1'b0;
    periph_addr = 16'h2468;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(OFF_COLL, RST_VAL);
    rd(ra(0, OFF_CTRL), RST_VAL);
    rd(8'h90, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cfg(0, codes[i], 16'h1000, 16'h0000, 16'h0000, 16'h0041);
      pulse(codes[i]);
      xfer(srcs[i], 16'h1000, 1'b0, 4'b0001);
    end
    wr(ra(0, OFF_CTRL), 16'h0000);
    $display("test source table done");
    cfg(1, SEL_EXT_INT_ZERO, 16'h1100, 16'h0000, 16'h0000, 16'h0041);
    ext_int0_pin <= 1'b1;
    xfer(16'h0000, 16'h1100, 1'b0, 4'b0010);
    ext_int0_pin <= 1'b0;
    wr(ra(1, OFF_CTRL), 16'h0000);
    cfg(2, SEL_COMPARE_ONE, 16'h1200, 16'h0000, 16'h0000, 16'h0053);
    pulse(SEL_COMPARE_ONE);
    xfer(16'h1200, ADDR_COMPARE_ONE_PRIMARY, 1'b0, 4'b0100);
    wr(ra(2, OFF_CTRL), 16'h0253);
    pulse(SEL_COMPARE_ONE);
    xfer(16'h1200, ADDR_COMPARE_ONE_SECONDARY, 1'b0, 4'b0100);
    wr(ra(2, OFF_CTRL), 16'h0000);
    $display("test int0 and compare done");
    cfg(3, SEL_CONVERTER_DONE, 16'h1301, 16'h0000, 16'h0003, 16'h004d);
    for (int i = 0; i < 4; i++) begin
      pulse(SEL_CONVERTER_DONE);
      xfer(16'h0300, 16'h1301 + 16'(i), 1'b1, (i == 1) ? 4'b1000 : 4'b0000);
    end
    pulse(SEL_CONVERTER_DONE);
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (bus.rd !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    @(posedge clk);
    $display("test byte half oneshot done");
    cfg(0, SEL_CAN_RX, 16'h1000, 16'h0000, 16'h0000, 16'h0041);
    cfg(1, SEL_CAN_RX, 16'h1100, 16'h0000, 16'h0000, 16'h0041);
    pulse(SEL_CAN_RX);
    xfer(ADDR_CAN_RECEIVE_DATA, 16'h1000, 1'b0, 4'b0001);
    xfer(ADDR_CAN_RECEIVE_DATA, 16'h1100, 1'b0, 4'b0010);
    wr(ra(0, OFF_CTRL), 16'h0000);
    $display("test priority done");
    cfg(2, SEL_CAPTURE_TWO, 16'h1400, 16'h1500, 16'h0000, 16'h0091);
    for (int i = 0; i < 3; i++) begin
      pulse(SEL_CAPTURE_TWO);
      xfer(ADDR_CAPTURE_TWO_BUFFER, (i == 1) ? 16'h1500 : 16'h1400, 1'b0, 4'b0100);
    end
    wr(ra(2, OFF_CTRL), 16'h0000);
    $display("test ping-pong done");
    cfg(1, SEL_SERIAL_ONE_RX, 16'h0000, 16'h0000, 16'h0000, 16'h0021);
    wr(ra(1, OFF_CTRL), 16'h0121);
    xfer(ADDR_SERIAL_ONE_RECEIVE, 16'h2468, 1'b0, 4'b0010);
    src_req[SEL_SERIAL_ONE_RX[6:0]] <= 1'b1;
    wr(ra(1, OFF_CTRL), 16'h0121);
    src_req[SEL_SERIAL_ONE_RX[6:0]] <= 1'b0;
    xfer(ADDR_SERIAL_ONE_RECEIVE, 16'h2468, 1'b0, 4'b0010);
    rd(OFF_COLL, 16'h0002);
    wr(OFF_COLL, 16'hffff);
    rd(OFF_COLL, 16'h0002);
    wr(ra(1, OFF_CTRL), 16'h0000);
    rd(OFF_COLL, 16'h0000);
    $display("test force and collision done");
    conclude();
  end
endmodule
